// ### isc_consts.svh
// Offsets, field positions, reset values and widths of the two-wire
// serial slave status/control block.
// Assumes a 32-bit Avalon-MM bus with byte addresses, one word per register.
`ifndef ISC_CONSTS_SVH
`define ISC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ISC_OFF_CTL 5'h00
`define ISC_OFF_DATA 5'h04
`define ISC_OFF_ADDR 5'h08
`define ISC_OFF_ISTAT 5'h0c
`define ISC_OFF_IMASK 5'h10

// ----------------------------------------------------------------------
// Status/control byte fields
// ----------------------------------------------------------------------
`define ISC_B_TXSEL 4
`define ISC_B_ACKDRV 3
`define ISC_B_WAKEEN 1
`define ISC_CTL_RST 8'h81

// ----------------------------------------------------------------------
// Interrupt status/mask fields
// ----------------------------------------------------------------------
`define ISC_I_DONE 0
`define ISC_I_MATCH 1
`define ISC_IRQ_W 2

// ----------------------------------------------------------------------
// Bus widths and bit counts
// ----------------------------------------------------------------------
`define ISC_AW 5
`define ISC_DW 32
`define ISC_LAST_BIT 4'h7
`define ISC_BYTE_BITS 4'h8

`endif

// ### isc_pkg.sv
// Types of the two-wire serial slave status/control block.
// Assumes isc_consts.svh is on the include path.
`include "isc_consts.svh"

package isc_pkg;

   // ----------------------------------------------------------------------
   // Bus carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic read;
      logic write;
      logic [`ISC_AW-1:0] address;
      logic [`ISC_DW-1:0] writedata;
   } isc_avs_req_t;

   typedef struct packed {
      logic [`ISC_DW-1:0] readdata;
      logic waitrequest;
   } isc_avs_rsp_t;

   // ----------------------------------------------------------------------
   // Link sequencer and module state
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      PH_IDLE, PH_ADDR, PH_ACK_ADDR, PH_RX, PH_ACK_RX, PH_TX, PH_ACK_TX,
      PH_WAIT
   } isc_phase_t;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      isc_phase_t phase;
      logic [3:0] bit_cnt;
      logic [7:0] shift;
      logic [7:0] data;
      logic [7:0] slv_addr;
      logic done;
      logic match;
      logic busy;
      logic tx_sel;
      logic ack_drv;
      logic dir;
      logic wake_en;
      logic ack_seen;
      logic sda_o;
      logic sda_oe;
      logic wake_req;
      logic [`ISC_IRQ_W-1:0] irq_status;
      logic [`ISC_IRQ_W-1:0] irq_mask;
      logic irq;
      logic waitreq;
      logic [`ISC_DW-1:0] readdata;
   } isc_state_t;

endpackage : isc_pkg

// ### isc_slave.sv
// Two-wire serial slave with status/control flags behind Avalon-MM.
// Assumes SCL and SDA arrive unsynchronised from pins, the bus wire is
// resolved outside from sda_oe, and the master never stretches SCL.
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "isc_consts.svh"

module isc_slave (
   // Clock and reset
   input wire logic clock,
   input wire logic rstn,
   // Register bus
   input wire isc_pkg::isc_avs_req_t avs_req,
   output isc_pkg::isc_avs_rsp_t avs_rsp,
   // Serial link pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // System requests
   output logic irq,
   output logic wake_req
);
   import isc_pkg::*;

   // Reset byte of the status/control register, read bit by bit below
   localparam logic [7:0] CTL_RST = `ISC_CTL_RST;

   isc_state_t s;
   isc_state_t n;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic quiet;
   logic [7:0] rx_byte;
   logic addr_hit;
   logic ev_done;
   logic ev_match;

   // ----------------------------------------------------------------------
   // Link edge and condition detection
   // ----------------------------------------------------------------------
   // Only the second synchroniser stage and its delayed copy are looked at
   assign scl_rise = s.scl_s2 & ~s.scl_d;
   assign scl_fall = ~s.scl_s2 & s.scl_d;
   assign start_det = s.scl_s2 & s.scl_d & ~s.sda_s2 & s.sda_d;
   assign stop_det = s.scl_s2 & s.scl_d & s.sda_s2 & ~s.sda_d;
   assign quiet = ~start_det & ~stop_det;
   assign rx_byte = {s.shift[6:0], s.sda_s2};
   assign addr_hit = (rx_byte[7:1] == s.slv_addr[7:1]);

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      n = s;
      ev_done = 1'b0;
      ev_match = 1'b0;
      n.scl_s1 = scl_in;
      n.scl_s2 = s.scl_s1;
      n.scl_d = s.scl_s2;
      n.sda_s1 = sda_in;
      n.sda_s2 = s.sda_s1;
      n.sda_d = s.sda_s2;
      n.wake_req = 1'b0;

      // Bus slave: one wait cycle, then the access takes effect
      if (!s.waitreq) begin
         n.waitreq = 1'b1;
         if (avs_req.write) begin
            unique case (avs_req.address)
               `ISC_OFF_CTL: begin
                  n.tx_sel = avs_req.writedata[`ISC_B_TXSEL];
                  n.ack_drv = avs_req.writedata[`ISC_B_ACKDRV];
                  n.wake_en = avs_req.writedata[`ISC_B_WAKEEN];
               end
               `ISC_OFF_DATA: n.data = avs_req.writedata[7:0];
               `ISC_OFF_ADDR: n.slv_addr = avs_req.writedata[7:0];
               `ISC_OFF_ISTAT: begin
                  n.irq_status = s.irq_status &
                     ~avs_req.writedata[`ISC_IRQ_W-1:0];
               end
               `ISC_OFF_IMASK: n.irq_mask = avs_req.writedata[`ISC_IRQ_W-1:0];
               default: ;
            endcase
         end else if (avs_req.read && avs_req.address == `ISC_OFF_DATA) begin
            n.done = 1'b0;
         end
      end else if (avs_req.read || avs_req.write) begin
         n.waitreq = 1'b0;
         n.readdata = 32'h0000_0000;
         if (avs_req.read) begin
            unique case (avs_req.address)
               `ISC_OFF_CTL: n.readdata[7:0] = {s.done, s.match, s.busy,
                  s.tx_sel, s.ack_drv, s.dir, s.wake_en, s.ack_seen};
               `ISC_OFF_DATA: n.readdata[7:0] = s.data;
               `ISC_OFF_ADDR: n.readdata[7:0] = s.slv_addr;
               `ISC_OFF_ISTAT: n.readdata[`ISC_IRQ_W-1:0] = s.irq_status;
               `ISC_OFF_IMASK: n.readdata[`ISC_IRQ_W-1:0] = s.irq_mask;
               default: ;
            endcase
         end
      end

      // Link sequencer; runs after the bus so hardware sets win
      if (start_det) begin
         n.phase = PH_ADDR;
         n.bit_cnt = 4'h0;
         n.busy = 1'b1;
         n.done = 1'b0;
         n.match = 1'b0;
         n.sda_oe = 1'b0;
      end else if (stop_det) begin
         n.phase = PH_IDLE;
         n.busy = 1'b0;
         n.done = 1'b1;
         n.sda_oe = 1'b0;
      end else begin
         unique case (s.phase)
            PH_IDLE, PH_WAIT: ;
            PH_ADDR, PH_RX: begin
               if (scl_rise) begin
                  n.shift = rx_byte;
                  n.bit_cnt = s.bit_cnt + 4'h1;
                  if (s.bit_cnt == 4'h0 && s.phase == PH_RX) begin
                     n.done = 1'b0;
                  end
                  if (s.bit_cnt == `ISC_LAST_BIT) begin
                     if (s.phase == PH_RX) begin
                        n.data = rx_byte;
                        n.done = 1'b1;
                        ev_done = 1'b1;
                     end else if (addr_hit) begin
                        n.match = 1'b1;
                        n.dir = rx_byte[0];
                        n.done = 1'b1;
                        ev_done = 1'b1;
                        ev_match = 1'b1;
                     end else begin
                        n.match = 1'b0;
                        n.phase = PH_WAIT;
                     end
                  end
               end else if (scl_fall && s.bit_cnt == `ISC_BYTE_BITS) begin
                  n.bit_cnt = 4'h0;
                  if (s.phase == PH_ADDR) begin
                     n.phase = PH_ACK_ADDR;
                     n.sda_oe = 1'b1;
                  end else begin
                     n.phase = PH_ACK_RX;
                     n.sda_oe = ~s.ack_drv;
                  end
               end
            end
            PH_ACK_ADDR: begin
               if (scl_fall) begin
                  n.bit_cnt = 4'h0;
                  if (s.tx_sel) begin
                     n.phase = PH_TX;
                     n.shift = s.data;
                     n.sda_oe = ~s.data[7];
                  end else begin
                     n.phase = PH_RX;
                     n.sda_oe = 1'b0;
                  end
               end
            end
            PH_ACK_RX: begin
               if (scl_fall) begin
                  n.phase = PH_RX;
                  n.sda_oe = 1'b0;
               end
            end
            PH_TX: begin
               if (scl_rise) begin
                  n.bit_cnt = s.bit_cnt + 4'h1;
                  if (s.bit_cnt == 4'h0) begin
                     n.done = 1'b0;
                  end
                  if (s.bit_cnt == `ISC_LAST_BIT) begin
                     n.done = 1'b1;
                     ev_done = 1'b1;
                  end
               end else if (scl_fall) begin
                  if (s.bit_cnt == `ISC_BYTE_BITS) begin
                     n.phase = PH_ACK_TX;
                     n.sda_oe = 1'b0;
                  end else begin
                     n.shift = {s.shift[6:0], 1'b0};
                     n.sda_oe = ~s.shift[6];
                  end
               end
            end
            PH_ACK_TX: begin
               if (scl_rise) begin
                  n.ack_seen = s.sda_s2;
               end else if (scl_fall) begin
                  // A missing acknowledge ends sending until the next START
                  if (!s.ack_seen) begin
                     n.phase = PH_TX;
                     n.bit_cnt = 4'h0;
                     n.shift = s.data;
                     n.sda_oe = ~s.data[7];
                  end else begin
                     n.phase = PH_WAIT;
                  end
               end
            end
         endcase
      end

      // Sticky events after the clear, so a same-cycle event survives
      n.irq_status[`ISC_I_DONE] = n.irq_status[`ISC_I_DONE] | ev_done;
      n.irq_status[`ISC_I_MATCH] = n.irq_status[`ISC_I_MATCH] | ev_match;
      n.irq = |(n.irq_status & n.irq_mask);
      n.wake_req = ev_match & s.wake_en;
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.scl_s1 <= 1'b1;
         s.scl_s2 <= 1'b1;
         s.scl_d <= 1'b1;
         s.sda_s1 <= 1'b1;
         s.sda_s2 <= 1'b1;
         s.sda_d <= 1'b1;
         s.done <= CTL_RST[7];
         s.ack_seen <= CTL_RST[0];
         s.waitreq <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign avs_rsp.readdata = s.readdata;
   assign avs_rsp.waitrequest = s.waitreq;
   assign sda_out = s.sda_o;
   assign sda_oe = s.sda_oe;
   assign irq = s.irq;
   assign wake_req = s.wake_req;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   AST_BYTE_DONE: assert property (@(posedge clock) disable iff (!rstn)
      (s.phase inside {PH_RX, PH_TX} && scl_rise && quiet &&
       s.bit_cnt == 4'h7) |=> (s.done && s.irq_status[0]))
      else $error("byte end did not set done and its event");
   AST_MOVING_LOW: assert property (@(posedge clock) disable iff (!rstn)
      (s.phase inside {PH_RX, PH_TX} && scl_rise && quiet &&
       s.bit_cnt == 4'h0) |=> !s.done)
      else $error("done high while a byte moves");
   AST_START_CLR: assert property (@(posedge clock) disable iff (!rstn)
      start_det |=> (!s.done && s.phase == PH_ADDR))
      else $error("START did not clear done");
   AST_READ_CLR: assert property (@(posedge clock) disable iff (!rstn)
      (!s.waitreq && avs_req.read && avs_req.address == 5'h04 &&
       !ev_done && !stop_det) |=> !s.done)
      else $error("data read did not clear done");
   AST_STOP_SET: assert property (@(posedge clock) disable iff (!rstn)
      stop_det |=> s.done)
      else $error("STOP did not set done");
   AST_MATCH: assert property (@(posedge clock) disable iff (!rstn)
      (s.phase == PH_ADDR && scl_rise && quiet &&
       s.bit_cnt == 4'h7) |=> (s.match == $past(addr_hit)))
      else $error("address match flag wrong");
   AST_BUSY_SET: assert property (@(posedge clock) disable iff (!rstn)
      start_det |=> s.busy [*1] ##1 (s.busy || $past(stop_det)))
      else $error("busy not set by START");
   AST_BUSY_CLR: assert property (@(posedge clock) disable iff (!rstn)
      stop_det |=> !s.busy)
      else $error("busy not cleared by STOP");
   AST_TX_SEL: assert property (@(posedge clock) disable iff (!rstn)
      (s.phase == PH_ACK_ADDR && scl_fall && quiet) |=>
      (s.phase == ($past(s.tx_sel) ? PH_TX : PH_RX)))
      else $error("direction select not followed");
   AST_ACK_PHASE: assert property (@(posedge clock) disable iff (!rstn)
      (s.phase == PH_RX && scl_fall && quiet &&
       s.bit_cnt == 4'h8) |=> (s.phase == PH_ACK_RX))
      else $error("no acknowledge clock after data byte");
   AST_ACK_LEVEL: assert property (@(posedge clock) disable iff (!rstn)
      (s.phase == PH_RX && scl_fall && quiet &&
       s.bit_cnt == 4'h8) |=> (s.sda_oe == !$past(s.ack_drv)))
      else $error("acknowledge drive does not follow control bit");
   AST_DIR: assert property (@(posedge clock) disable iff (!rstn)
      ev_match |=> (s.dir == $past(s.sda_s2)))
      else $error("read/write bit not captured");
   AST_ACK_SEEN: assert property (@(posedge clock) disable iff (!rstn)
      (s.phase == PH_ACK_TX && scl_rise && quiet) |=>
      (s.ack_seen == $past(s.sda_s2)))
      else $error("received acknowledge not stored");
   AST_MATCH_IRQ: assert property (@(posedge clock) disable iff (!rstn)
      (ev_match && s.irq_mask[1]) |=> (s.irq_status[1] && s.irq))
      else $error("match did not raise interrupt");
   AST_WAKE: assert property (@(posedge clock) disable iff (!rstn)
      (ev_match && s.wake_en) |=> wake_req)
      else $error("match did not request wake-up");
   AST_RO: assert property (@(posedge clock) disable iff (!rstn)
      (!s.waitreq && avs_req.write && avs_req.address == 5'h00 && quiet &&
       !scl_rise && !ev_done && !ev_match) |=>
      (s.done == $past(s.done) &&
       s.tx_sel == $past(avs_req.writedata[`ISC_B_TXSEL])))
      else $error("control write misbehaved");

endmodule : isc_slave

// ### isc_master_model.sv
// Two-wire bus master model: drives SCL and pulls SDA low.
// Assumes the bench resolves SDA with a pull-up and supplies the clock.
`timescale 1ns/1ps

module isc_master_model (
   // Clock
   input wire logic clock,
   // Bus lines
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // ------
   // Bit timing, a quarter is 200 ns
   // ------
   task q;
      repeat (2) @(posedge clock);
   endtask : q

   task bit_put(input logic b);
      sda_low <= !b;
      q;
      scl <= 1'b1;
      q;
      q;
      scl <= 1'b0;
      q;
   endtask : bit_put

   task bit_get(output logic b);
      sda_low <= 1'b0;
      q;
      scl <= 1'b1;
      q;
      b = sda;
      q;
      scl <= 1'b0;
      q;
   endtask : bit_get

   // Extra quarter lets the slave drop its acknowledge first
   task start;
      sda_low <= 1'b0;
      q;
      q;
      scl <= 1'b1;
      q;
      sda_low <= 1'b1;
      q;
      scl <= 1'b0;
      q;
   endtask : start

   task stop;
      sda_low <= 1'b1;
      q;
      scl <= 1'b1;
      q;
      sda_low <= 1'b0;
      q;
      q;
   endtask : stop

   task byte_put(input logic [7:0] d, output logic nack);
      for (int i = 7; i >= 0; i--) bit_put(d[i]);
      bit_get(nack);
   endtask : byte_put

   task byte_get(output logic [7:0] d, input logic nack);
      for (int i = 7; i >= 0; i--) bit_get(d[i]);
      bit_put(nack);
   endtask : byte_get
endmodule : isc_master_model

// ### tb_isc_slave.sv
// Self-checking bench of the two-wire slave status/control block.
// Assumes isc_pkg, isc_slave and isc_master_model are compiled first.
`timescale 1ns/1ps
`include "isc_consts.svh"

module tb_isc_slave;
   import isc_pkg::*;
   logic clock, rstn, scl, sda, sda_low, sda_out, sda_oe;
   logic irq, wake_req, wake_seen, nk;
   logic [7:0] b;
   isc_avs_req_t avs_req;
   isc_avs_rsp_t avs_rsp;
   int num_errors, checks;

   // Open drain wire with pull-up
   assign sda = !(sda_low || (sda_oe && !sda_out));

   isc_slave i_isc_slave (.clock(clock), .rstn(rstn), .avs_req(avs_req),
      .avs_rsp(avs_rsp), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .irq(irq), .wake_req(wake_req));
   isc_master_model i_isc_master_model (.clock(clock), .sda(sda),
      .scl(scl), .sda_low(sda_low));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Pulse is one cycle wide, so it is latched here
   always @(posedge clock) if (wake_req === 1'b1) wake_seen <= 1'b1;

   // ------
   // Common tasks
   // ------
   task finish_test;
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
      output logic [31:0] rd);
      int n;
      @(posedge clock);
      avs_req <= '{read: !wr, write: wr, address: a, writedata: d};
      n = 0;
      @(posedge clock);
      while (avs_rsp.waitrequest !== 1'b0) begin
         n++;
         if (n > 20) begin
            num_errors++;
            finish_test();
         end
         @(posedge clock);
      end
      rd = avs_rsp.readdata;
      avs_req <= '0;
   endtask : bus

   task wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask : wr

   task exp_reg(input logic [4:0] a, input logic [31:0] m,
      input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0000_0000, x);
      check(x & m, e);
   endtask : exp_reg

   task settle;
      repeat (2) @(posedge clock);
   endtask : settle

   // ------
   // Scenarios
   // ------
   task t_regs;
      exp_reg(`ISC_OFF_CTL, 32'h0000_ffff, {24'h0, `ISC_CTL_RST});
      wr(`ISC_OFF_CTL, 32'hffff_ffff);
      exp_reg(`ISC_OFF_CTL, 32'hffff_ffff, 32'h0000_009b);
      wr(`ISC_OFF_CTL, 32'h0000_0000);
      exp_reg(`ISC_OFF_CTL, 32'hffff_ffff, 32'h0000_0081);
      exp_reg(5'h14, 32'hffff_ffff, 32'h0000_0000);
      check(32'(irq), 32'h0000_0000);
   endtask : t_regs

   task t_rx;
      wr(`ISC_OFF_ADDR, 32'h0000_00a4);
      wr(`ISC_OFF_IMASK, 32'h0000_0003);
      i_isc_master_model.start();
      exp_reg(`ISC_OFF_CTL, 32'h0000_00e0, 32'h0000_0020);
      i_isc_master_model.byte_put(8'ha4, nk);
      check(32'(nk), 32'h0000_0000);
      exp_reg(`ISC_OFF_CTL, 32'h0000_00e4, 32'h0000_00e0);
      check(32'(irq), 32'h0000_0001);
      exp_reg(`ISC_OFF_ISTAT, 32'hffff_ffff, 32'h0000_0003);
      wr(`ISC_OFF_ISTAT, 32'h0000_0003);
      settle;
      check(32'(irq), 32'h0000_0000);
      b = 8'h3c;
      for (int i = 7; i >= 4; i--) i_isc_master_model.bit_put(b[i]);
      exp_reg(`ISC_OFF_CTL, 32'h0000_0080, 32'h0000_0000);
      for (int i = 3; i >= 0; i--) i_isc_master_model.bit_put(b[i]);
      i_isc_master_model.bit_get(nk);
      check(32'(nk), 32'h0000_0000);
      exp_reg(`ISC_OFF_CTL, 32'h0000_0080, 32'h0000_0080);
      exp_reg(`ISC_OFF_ISTAT, 32'h0000_0001, 32'h0000_0001);
      exp_reg(`ISC_OFF_DATA, 32'h0000_00ff, 32'h0000_003c);
      exp_reg(`ISC_OFF_CTL, 32'h0000_0080, 32'h0000_0000);
      wr(`ISC_OFF_CTL, 32'h0000_0008);
      i_isc_master_model.byte_put(8'h55, nk);
      check(32'(nk), 32'h0000_0001);
      i_isc_master_model.stop();
      exp_reg(`ISC_OFF_CTL, 32'h0000_00a0, 32'h0000_0080);
      wr(`ISC_OFF_ISTAT, 32'h0000_0003);
   endtask : t_rx

   task t_nomatch;
      wr(`ISC_OFF_IMASK, 32'h0000_0002);
      i_isc_master_model.start();
      i_isc_master_model.byte_put(8'ha6, nk);
      check(32'(nk), 32'h0000_0001);
      exp_reg(`ISC_OFF_CTL, 32'h0000_0040, 32'h0000_0000);
      settle;
      check(32'(irq), 32'h0000_0000);
      i_isc_master_model.stop();
      wr(`ISC_OFF_ISTAT, 32'h0000_0003);
   endtask : t_nomatch

   task t_tx;
      wr(`ISC_OFF_IMASK, 32'h0000_0000);
      wr(`ISC_OFF_DATA, 32'h0000_00c3);
      wr(`ISC_OFF_CTL, 32'h0000_0012);
      wake_seen <= 1'b0;
      i_isc_master_model.start();
      i_isc_master_model.byte_put(8'ha5, nk);
      check(32'(nk), 32'h0000_0000);
      exp_reg(`ISC_OFF_CTL, 32'h0000_0044, 32'h0000_0044);
      check(32'(wake_seen), 32'h0000_0001);
      exp_reg(`ISC_OFF_ISTAT, 32'h0000_0002, 32'h0000_0002);
      check(32'(irq), 32'h0000_0000);
      i_isc_master_model.byte_get(b, 1'b0);
      check(32'(b), 32'h0000_00c3);
      exp_reg(`ISC_OFF_CTL, 32'h0000_0001, 32'h0000_0000);
      i_isc_master_model.byte_get(b, 1'b1);
      check(32'(b), 32'h0000_00c3);
      exp_reg(`ISC_OFF_CTL, 32'h0000_0001, 32'h0000_0001);
      i_isc_master_model.stop();
      wr(`ISC_OFF_ISTAT, 32'h0000_0003);
   endtask : t_tx

   initial begin
      #5_000_000;
      num_errors++;
      finish_test();
   end

   initial begin
      avs_req = '0;
      rstn = 1'b0;
      wake_seen = 1'b0;
      num_errors = 0;
      checks = 0;
      repeat (8) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      t_regs;
      t_rx;
      t_nomatch;
      t_tx;
      finish_test();
   end
endmodule : tb_isc_slave
